// ---- design/afs_filter.sv ----
`timescale 1ns/1ps

module afs_filter #(
   parameter int CYCLES = 2000
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Synchronised raw condition
   input  wire logic raw_i,
   // Filtered level
   output logic      level_o
);

   localparam int CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

   logic [CNT_W-1:0] cnt_q;
   logic             level_q;

   // Count while present, restart on any gap
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= '0;
         level_q <= 1'b0;
      end else if (!raw_i) begin
         cnt_q <= '0;
         level_q <= 1'b0;
      end else begin
         if (cnt_q != LAST) begin
            cnt_q <= cnt_q + 1'b1;
         end
         level_q <= level_q | (cnt_q == LAST);
      end
   end

   assign level_o = level_q;

   // Gap drops the count and the level
   a_filter_restart: assert property (@(posedge clk) disable iff (sys_rst)
      !raw_i |=> (cnt_q == '0) && !level_q)
      else $error("filter did not restart on gap");

   // Level rises only after the full count
   a_filter_delay: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(level_q) |-> $past(cnt_q) == LAST && $past(raw_i))
      else $error("filter level rose early");

endmodule

// ---- design/afs_supervisor.sv ----
`timescale 1ns/1ps

module afs_supervisor #(
   parameter int OL_FILTER_CYCLES = afs_pkg::OL_FILTER_CYC
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // Serial link from the controller
   input  wire logic                serial_clk,
   input  wire logic                serial_din,
   input  wire logic                serial_select_low,
   output logic                     serial_dout,
   output logic                     serial_dout_oe,
   // Analog monitor comparators
   input  wire afs_pkg::afs_diag_t  diag_raw,
   input  wire logic                charge_pump_ok,
   input  wire logic                temp_below_hysteresis,
   input  wire logic                logic_supply_low,
   // Power stage control
   output logic [10:0]              driver_on,
   output logic                     stages_hiz,
   output afs_pkg::afs_cm_t         cm_select,
   output logic                     active_mode
);

   localparam int N = afs_pkg::NUM_DRV;
   localparam int DW = $bits(afs_pkg::afs_diag_t);
   localparam int SW = DW + 6;
   // Select idles high so a reset synchroniser must not fake a frame
   localparam logic [SW-1:0] SYNC_RST = {3'b001, 3'b000, {DW{1'b0}}};

   logic [SW-1:0]          meta_q;
   logic [SW-1:0]          sync_q;
   logic                   sclk_s;
   logic                   sdi_s;
   logic                   cs_s;
   logic                   cp_ok_s;
   logic                   cool_s;
   logic                   vcc_low_s;
   afs_pkg::afs_diag_t     diag_s;
   logic                   sclk_d_q;
   logic                   cs_d_q;
   logic                   vcc_low_d_q;
   logic                   sclk_rise;
   logic                   sclk_fall;
   logic                   cs_fall;
   logic                   cs_rise;
   logic                   wipe;

   afs_pkg::afs_spi_st_t   spi_st_q;
   logic [4:0]             bit_cnt_q;
   logic [15:0]            rx_q;
   logic [15:0]            tx_q;
   logic                   commit_q;
   afs_pkg::afs_ctrl_t     word_q;
   afs_pkg::afs_ctrl_t     ctrl_q;
   logic                   active_q;
   logic                   sdo_q;
   logic                   sdo_oe_q;

   logic [N-1:0]           ovc_f;
   logic [N-1:0]           ol_f;
   logic [3:0]             misc_raw;
   logic [3:0]             misc_f;
   logic                   sov_f;
   logic                   suv_f;
   logic                   tw_f;
   logic                   tsd_f;
   afs_pkg::afs_stat0_t    stat0_q;
   afs_pkg::afs_stat1_t    stat1_q;
   logic                   clr_flags;
   logic                   stby_clr;
   logic                   supply_block;
   logic [N-1:0]           driver_on_q;
   logic                   stages_hiz_q;
   afs_pkg::afs_cm_t       cm_select_q;

   // Mode code to monitored output
   function automatic afs_pkg::afs_cm_t cm_decode(input logic [1:0] mode);
      afs_pkg::afs_cm_t sel;
      sel = afs_pkg::CM_NONE;
      case (mode)
         2'b01: sel = afs_pkg::CM_BRIDGE_A;
         2'b10: sel = afs_pkg::CM_BRIDGE_B;
         2'b11: sel = afs_pkg::CM_HEATER;
         default: sel = afs_pkg::CM_NONE;
      endcase
      return sel;
   endfunction

   // Two-stage synchroniser for every pin from outside the clock domain
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= SYNC_RST;
         sync_q <= SYNC_RST;
      end else begin
         meta_q <= {serial_clk, serial_din, serial_select_low,
                    charge_pump_ok, temp_below_hysteresis,
                    logic_supply_low, diag_raw};
         sync_q <= meta_q;
      end
   end

   assign sclk_s = sync_q[SW-1];
   assign sdi_s = sync_q[SW-2];
   assign cs_s = sync_q[SW-3];
   assign cp_ok_s = sync_q[SW-4];
   assign cool_s = sync_q[SW-5];
   assign vcc_low_s = sync_q[SW-6];
   assign diag_s = sync_q[DW-1:0];

   // Delayed copies for edge detection, never fed from the first stage
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclk_d_q <= 1'b0;
         cs_d_q <= 1'b1;
         vcc_low_d_q <= 1'b0;
      end else begin
         sclk_d_q <= sclk_s;
         cs_d_q <= cs_s;
         vcc_low_d_q <= vcc_low_s;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_d_q;
   assign sclk_fall = ~sclk_s & sclk_d_q;
   assign cs_fall = ~cs_s & cs_d_q;
   assign cs_rise = cs_s & ~cs_d_q;
   // Held one cycle past the supply's return to act as power-on reset
   assign wipe = vcc_low_s | vcc_low_d_q;

   // Serial frame engine: sample on rising clock, shift out on falling
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         spi_st_q <= afs_pkg::SPI_IDLE;
         bit_cnt_q <= 5'h00;
         rx_q <= 16'h0000;
         tx_q <= 16'h0000;
         commit_q <= 1'b0;
      end else begin
         commit_q <= 1'b0;
         case (spi_st_q)
            afs_pkg::SPI_IDLE: begin
               if (cs_fall && !wipe) begin
                  // Status page chosen by the previous frame
                  tx_q <= ctrl_q.page ? 16'(stat1_q)
                                      : 16'(stat0_q);
                  bit_cnt_q <= 5'h00;
                  spi_st_q <= afs_pkg::SPI_SHIFT;
               end
            end
            afs_pkg::SPI_SHIFT: begin
               if (cs_s || wipe) begin
                  spi_st_q <= afs_pkg::SPI_IDLE;
                  // Frames of any other length are dropped
                  commit_q <= cs_rise && !wipe &&
                              (bit_cnt_q == afs_pkg::FRAME_BITS);
               end else begin
                  if (sclk_rise) begin
                     rx_q <= {sdi_s, rx_q[15:1]};
                     if (bit_cnt_q != afs_pkg::BIT_CNT_MAX) begin
                        bit_cnt_q <= bit_cnt_q + 5'h01;
                     end
                  end
                  if (sclk_fall) begin
                     tx_q <= {1'b0, tx_q[15:1]};
                  end
               end
            end
            default: spi_st_q <= afs_pkg::SPI_IDLE;
         endcase
      end
   end

   // Serial output pin, floated while deselected
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sdo_q <= 1'b0;
         sdo_oe_q <= 1'b0;
      end else begin
         sdo_q <= tx_q[0];
         sdo_oe_q <= ~cs_s && (spi_st_q == afs_pkg::SPI_SHIFT);
      end
   end

   // Frame capture register, taken once per good frame
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         word_q <= afs_pkg::CTRL_RST;
      end else if (cs_rise && (bit_cnt_q == afs_pkg::FRAME_BITS)) begin
         word_q <= rx_q;
      end
   end

   // Control word; supply loss returns it to standby
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= afs_pkg::CTRL_RST;
      end else if (wipe) begin
         ctrl_q <= afs_pkg::CTRL_RST;
      end else if (commit_q) begin
         ctrl_q <= word_q;
      end
   end

   // Active whenever either mode bit is set
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         active_q <= 1'b0;
      end else begin
         active_q <= (ctrl_q.mode != 2'b00);
      end
   end

   // Diagnostic filters per driver
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_drv_flt
         afs_filter #(
            .CYCLES (afs_pkg::OVC_FILTER_CYC)
         ) u_ovc (
            .clk     (clk),
            .sys_rst (sys_rst),
            .raw_i   (diag_s.ovc[gi]),
            .level_o (ovc_f[gi])
         );
         afs_filter #(
            .CYCLES (OL_FILTER_CYCLES)
         ) u_ol (
            .clk     (clk),
            .sys_rst (sys_rst),
            .raw_i   (diag_s.ol[gi]),
            .level_o (ol_f[gi])
         );
      end
   endgenerate

   // Supply and temperature filters
   assign misc_raw = {diag_s.sov, diag_s.suv, diag_s.tw, diag_s.tsd};
   generate
      for (gi = 0; gi < 4; gi++) begin : g_misc_flt
         afs_filter #(
            .CYCLES (afs_pkg::DIAG_FILTER_CYC)
         ) u_misc (
            .clk     (clk),
            .sys_rst (sys_rst),
            .raw_i   (misc_raw[gi]),
            .level_o (misc_f[gi])
         );
      end
   endgenerate

   assign sov_f = misc_f[3];
   assign suv_f = misc_f[2];
   assign tw_f = misc_f[1];
   assign tsd_f = misc_f[0];

   assign clr_flags = commit_q & word_q.clear_status;
   assign stby_clr = commit_q & (word_q.mode == 2'b00);

   // Sticky status flags; a new event beats a same-cycle clear
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stat0_q <= afs_pkg::STAT0_RST;
         stat1_q <= afs_pkg::STAT1_RST;
      end else if (wipe || stby_clr) begin
         stat0_q <= afs_pkg::STAT0_RST;
         stat1_q <= afs_pkg::STAT1_RST;
      end else begin
         stat0_q.ovc <= (stat0_q.ovc & ~{N{clr_flags}}) |
                        (ovc_f & {N{active_q}});
         stat1_q.ol <= (stat1_q.ol & ~{N{clr_flags}}) |
                       (ol_f & {N{active_q}});
         stat0_q.sov <= (stat0_q.sov & ~clr_flags) | (sov_f & active_q);
         stat0_q.suv <= (stat0_q.suv & ~clr_flags) | (suv_f & active_q);
         stat0_q.tw <= (stat0_q.tw & ~clr_flags) |
                       (tw_f & active_q);
         // Shutdown flag ignores a flag clear until the die has cooled; supply loss or a standby frame still clears it
         stat0_q.tsd <= (stat0_q.tsd & ~(clr_flags & cool_s)) |
                        (tsd_f & active_q);
      end
   end

   // Supply hold-off: auto release, or flag clear when locked out
   assign supply_block =
      sov_f | (ctrl_q.lockout & stat0_q.sov) |
      suv_f | (stat0_q.suv & ~cp_ok_s) |
      (ctrl_q.lockout & stat0_q.suv);

   // Driver gating; open-load and warning flags deliberately not used
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         driver_on_q <= '0;
         stages_hiz_q <= 1'b1;
      end else if (wipe) begin
         driver_on_q <= '0;
         stages_hiz_q <= 1'b1;
      end else begin
         if (active_q && !stat0_q.tsd && !supply_block) begin
            driver_on_q <= ctrl_q.drive &
                           ~stat0_q.ovc;
         end else begin
            driver_on_q <= '0;
         end
         stages_hiz_q <= ~active_q | supply_block;
      end
   end

   // Current-monitor mux select follows the mode bits
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cm_select_q <= afs_pkg::CM_NONE;
      end else begin
         cm_select_q <= cm_decode(ctrl_q.mode);
      end
   end

   assign serial_dout = sdo_q;
   assign serial_dout_oe = sdo_oe_q;
   assign driver_on = driver_on_q;
   assign stages_hiz = stages_hiz_q;
   assign cm_select = cm_select_q;
   assign active_mode = active_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_frame_end;
      cs_rise && spi_st_q == afs_pkg::SPI_SHIFT && !wipe &&
      bit_cnt_q == afs_pkg::FRAME_BITS;
   endsequence

   sequence s_commit_applied;
      commit_q ##1 (ctrl_q == $past(word_q));
   endsequence

   a_frame_commit: assert property (
      s_frame_end |=> s_commit_applied)
      else $error("good frame not applied to control word");

   a_dout_float: assert property (cs_s |=> !serial_dout_oe)
      else $error("serial output driven while deselected");

   a_supply_loss: assert property (vcc_low_s |=>
      stat0_q == 16'h0000 && stat1_q == 16'h0000 &&
      stages_hiz && driver_on == 11'h000)
      else $error("logic supply loss did not clear");

   a_supply_return: assert property ($fell(vcc_low_s) |=>
      ctrl_q == afs_pkg::CTRL_RST ##1 !active_mode)
      else $error("logic supply return did not reinitialise");

   a_standby_off: assert property (!active_q |=> stages_hiz &&
      driver_on == 11'h000)
      else $error("standby left a stage driven");

   a_mode_active: assert property (
      (ctrl_q.mode != 2'b00) |=> active_q)
      else $error("mode bits set but not active");

   a_ovc_driver_off: assert property (1'b1 |=>
      (driver_on & $past(stat0_q.ovc)) == 11'h000)
      else $error("overloaded driver still on");

   a_tsd_all_off: assert property (
      stat0_q.tsd |=> driver_on == 11'h000)
      else $error("driver on during thermal shutdown");

   a_tw_flag: assert property (
      tw_f && active_q && !wipe && !stby_clr |=> stat0_q.tw)
      else $error("temperature warning not flagged");

   a_ol_flag: assert property (
      (ol_f != 11'h000) && active_q && !wipe && !stby_clr |=>
      (stat1_q.ol & $past(ol_f)) == $past(ol_f))
      else $error("open load not flagged");

   a_lockout_hold: assert property (ctrl_q.lockout && !wipe &&
      (stat0_q.sov || stat0_q.suv) |=> stages_hiz && driver_on == 11'h000)
      else $error("locked-out driver restarted itself");

   a_ovvolt_float: assert property (sov_f && !wipe |=> stages_hiz)
      else $error("overvoltage did not float stages");

endmodule

// ---- inc/afs_pkg.sv ----
package afs_pkg;

   // Geometry of the driver array and the serial frame
   localparam int NUM_DRV = 11;
   localparam int FRAME_W = 16;
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [4:0] BIT_CNT_MAX = 5'h1F;

   // Clock and filter times, each time in its own unit
   localparam int CLK_PERIOD_NS = 5;
   localparam int OVC_FILTER_NS = 10000;
   localparam int DIAG_FILTER_NS = 10000;
   localparam int OL_FILTER_US = 500;
   localparam int OVC_FILTER_CYC =
      (OVC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIAG_FILTER_CYC =
      (DIAG_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OL_FILTER_CYC =
      (OL_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Control word field positions
   localparam int CTRL_PAGE_BIT = 0;
   localparam int CTRL_DRV_LSB = 1;
   localparam int CTRL_MODE_LSB = 12;
   localparam int CTRL_LOCK_BIT = 14;
   localparam int CTRL_CLR_BIT = 15;

   // Control word as shifted in, bit 0 first
   typedef struct packed {
      logic             clear_status;
      logic             lockout;
      logic [1:0]       mode;
      logic [10:0]      drive;
      logic             page;
   } afs_ctrl_t;

   // Status word zero: overload flags and supply/temperature flags
   typedef struct packed {
      logic             tw;
      logic             tsd;
      logic             suv;
      logic             sov;
      logic [10:0]      ovc;
      logic             rsvd;
   } afs_stat0_t;

   // Status word one: open-load flags
   typedef struct packed {
      logic [3:0]       rsvd_hi;
      logic [10:0]      ol;
      logic             rsvd;
   } afs_stat1_t;

   // Raw comparator outputs from the analog side
   typedef struct packed {
      logic [10:0]      ovc;
      logic [10:0]      ol;
      logic             sov;
      logic             suv;
      logic             tw;
      logic             tsd;
   } afs_diag_t;

   // Reset values
   localparam afs_ctrl_t CTRL_RST = 16'h0000;
   localparam afs_stat0_t STAT0_RST = 16'h0000;
   localparam afs_stat1_t STAT1_RST = 16'h0000;

   // Current-monitor routing
   typedef enum logic [1:0] {
      CM_NONE     = 2'b00,
      CM_BRIDGE_A = 2'b01,
      CM_BRIDGE_B = 2'b10,
      CM_HEATER   = 2'b11
   } afs_cm_t;

   // Serial frame states
   typedef enum logic {
      SPI_IDLE  = 1'b0,
      SPI_SHIFT = 1'b1
   } afs_spi_st_t;

endpackage

// ---- testbench/actuator_fault_supervisor_tb_top.sv ----
`timescale 1ns/1ps

module actuator_fault_supervisor_tb_top;
   localparam logic [15:0] ON  = 16'h1FFE;
   localparam logic [15:0] CLR = 16'h8000;
   localparam logic [15:0] LCK = 16'h4000;

   // Bench signals
   logic                clk;
   logic                sys_rst;
   logic                serial_clk;
   logic                serial_din;
   logic                serial_select_low;
   logic                serial_dout;
   logic                serial_dout_oe;
   logic                dout_line;
   afs_pkg::afs_diag_t  diag;
   logic                pump_ok;
   logic                cool;
   logic                vcc_low;
   logic [10:0]         driver_on;
   logic                stages_hiz;
   afs_pkg::afs_cm_t    cm_select;
   logic                active_mode;
   logic [15:0]         rd;
   int                  mismatches;
   int                  checked;

   // Clock, 5 ns period
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Short open-load filter keeps the run brief
   afs_supervisor #(.OL_FILTER_CYCLES(50)) DUT (
      .clk(clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
      .serial_din(serial_din), .serial_select_low(serial_select_low),
      .serial_dout(serial_dout), .serial_dout_oe(serial_dout_oe),
      .diag_raw(diag), .charge_pump_ok(pump_ok),
      .temp_below_hysteresis(cool), .logic_supply_low(vcc_low),
      .driver_on(driver_on), .stages_hiz(stages_hiz),
      .cm_select(cm_select), .active_mode(active_mode));

   // Floated data line shows the inverse, so a early release is caught
   assign dout_line = serial_dout_oe ? serial_dout : ~serial_dout;

   afs_spi_master MCU (
      .clk(clk), .serial_clk(serial_clk), .serial_din(serial_din),
      .serial_select_low(serial_select_low), .serial_dout(dout_line));

   task automatic report_and_stop;
      if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic frame(input logic [15:0] w);
      MCU.xfer(w, 16, rd);
   endtask

   // Readback shows the page committed by the frame before
   task automatic status(input logic [15:0] w);
      frame(w);
      frame(w);
      MCU.xfer(w, 16, rd);
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic t_modes;
      chk({5'h00, driver_on}, 16'h0000);
      chk({15'h0, stages_hiz}, 16'h0001);
      for (int m = 1; m < 4; m++) begin
         frame({2'b00, 2'(m), 12'hFFE});
         chk({14'h0, cm_select}, 16'(m));
         chk({15'h0, active_mode}, 16'h0001);
         chk({5'h00, driver_on}, 16'h07FF);
      end
      frame(16'h0FFE);
      chk({15'h0, active_mode}, 16'h0000);
      chk({5'h00, driver_on}, 16'h0000);
      chk({15'h0, stages_hiz}, 16'h0001);
      chk({14'h0, cm_select}, 16'h0000);
      MCU.xfer(ON, 15, rd);
      chk({15'h0, active_mode}, 16'h0000);
      chk({15'h0, serial_dout_oe}, 16'h0000);
   endtask

   task automatic t_overload;
      frame(ON);
      diag.ovc[3] <= 1'b1;
      wait_clk(1500);
      diag.ovc[3] <= 1'b0;
      wait_clk(3);
      diag.ovc[3] <= 1'b1;
      wait_clk(1500);
      chk({5'h00, driver_on}, 16'h07FF);
      wait_clk(600);
      diag.ovc[3] <= 1'b0;
      wait_clk(10);
      chk({5'h00, driver_on}, 16'h07F7);
      status(ON);
      chk(rd, 16'h0010);
      frame(ON | CLR);
      chk({5'h00, driver_on}, 16'h07FF);
   endtask

   task automatic t_info;
      diag.ol[5] <= 1'b1;
      diag.tw <= 1'b1;
      wait_clk(2010);
      diag.ol[5] <= 1'b0;
      diag.tw <= 1'b0;
      chk({5'h00, driver_on}, 16'h07FF);
      status(ON | 16'h0001);
      chk(rd, 16'h0040);
      status(ON);
      chk(rd, 16'h8000);
   endtask

   task automatic t_thermal;
      cool <= 1'b0;
      frame(ON | CLR);
      diag.tsd <= 1'b1;
      wait_clk(2010);
      diag.tsd <= 1'b0;
      chk({5'h00, driver_on}, 16'h0000);
      frame(ON | CLR);
      chk({5'h00, driver_on}, 16'h0000);
      cool <= 1'b1;
      frame(ON | CLR);
      chk({5'h00, driver_on}, 16'h07FF);
   endtask

   task automatic t_supply;
      diag.sov <= 1'b1;
      wait_clk(2010);
      chk({stages_hiz, 4'h0, driver_on}, 16'h8000);
      diag.sov <= 1'b0;
      wait_clk(10);
      chk({stages_hiz, 4'h0, driver_on}, 16'h07FF);
      frame(ON | LCK | CLR);
      diag.sov <= 1'b1;
      wait_clk(2010);
      diag.sov <= 1'b0;
      wait_clk(10);
      chk({5'h00, driver_on}, 16'h0000);
      frame(ON | LCK | CLR);
      chk({5'h00, driver_on}, 16'h07FF);
      frame(ON | CLR);
      pump_ok <= 1'b0;
      diag.suv <= 1'b1;
      wait_clk(2010);
      diag.suv <= 1'b0;
      wait_clk(10);
      chk({stages_hiz, 4'h0, driver_on}, 16'h8000);
      pump_ok <= 1'b1;
      wait_clk(10);
      chk({stages_hiz, 4'h0, driver_on}, 16'h07FF);
   endtask

   // Logic-supply loss while the undervoltage flag is still set
   task automatic t_vcc_loss;
      vcc_low <= 1'b1;
      wait_clk(5);
      chk({stages_hiz, 4'h0, driver_on}, 16'h8000);
      vcc_low <= 1'b0;
      wait_clk(5);
      chk({15'h0, active_mode}, 16'h0000);
      status(ON);
      chk(rd, 16'h0000);
   endtask

   // Main sequence
   initial begin
      sys_rst = 1'b1;
      diag = '0;
      pump_ok = 1'b1;
      cool = 1'b1;
      vcc_low = 1'b0;
      mismatches = 0;
      checked = 0;
      wait_clk(20);
      sys_rst <= 1'b0;
      wait_clk(5);
      t_modes();
      t_overload();
      t_info();
      t_thermal();
      t_supply();
      t_vcc_loss();
      report_and_stop();
   end

   // Watchdog, well beyond the expected 27k cycles
   initial begin
      wait_clk(90000);
      mismatches++;
      report_and_stop();
   end
endmodule

// ---- testbench/afs_spi_master.sv ----
`timescale 1ns/1ps

// Controller on the far side of the serial link, run by task calls
module afs_spi_master (
   // Clock that paces the controller
   input  wire logic clk,
   // Serial pins
   output logic      serial_clk,
   output logic      serial_din,
   output logic      serial_select_low,
   input  wire logic serial_dout
);
   // Idle: deselected, clock low
   initial begin
      serial_clk        = 1'b0;
      serial_din        = 1'b0;
      serial_select_low = 1'b1;
   end

   // One frame, bit 0 first; a short count gives a refused frame
   task automatic xfer(input logic [15:0] w, input int nbits,
                       output logic [15:0] rd);
      rd = 16'h0000;
      @(posedge clk) serial_select_low <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < nbits; i++) begin
         serial_din <= w[i];
         repeat (16) @(posedge clk);
         rd[i] = serial_dout;
         serial_clk <= 1'b1;
         repeat (16) @(posedge clk);
         serial_clk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      serial_select_low <= 1'b1;
      // Released line must not keep showing the last bit
      serial_din <= ~serial_din;
      repeat (8) @(posedge clk);
   endtask
endmodule
